// File: ltw_pkg.sv
// Constants and types shared by the lite timebase, watchdog and capture block.
`default_nettype none
package ltw_pkg;
	// Register indices; byte address on the bus is four times the index.
	localparam logic [7:0] CSR_IDX = 8'h0b;
	localparam logic [7:0] CAP_IDX = 8'h0c;
	localparam logic [7:0] CSR_ADDR = {CSR_IDX[5:0], 2'b00};
	localparam logic [7:0] CAP_ADDR = {CAP_IDX[5:0], 2'b00};
	// Control/status bit positions.
	localparam int B_CAP_IE = 7;
	localparam int B_CAP_FLAG = 6;
	localparam int B_PERIOD = 5;
	localparam int B_TICK_IE = 4;
	localparam int B_TICK_FLAG = 3;
	localparam int B_FORCE = 2;
	localparam int B_DOG_EN = 1;
	localparam int B_DELAY = 0;
	// Reset values.
	localparam logic [7:0] CAP_RESET = 8'h00;
	localparam logic CAP_FLAG_RESET = 1'b0;
	// Prescaler and counter.
	localparam int PRESC_DIV = 32;
	localparam logic [4:0] PRESC_LAST = 5'(PRESC_DIV - 1);
	localparam logic [7:0] CNT_TOP = 8'hf9;
	localparam int OVF_OSC_PERIODS = PRESC_DIV * (int'(CNT_TOP) + 1);
	localparam int TICK_SHORT = 8000;
	localparam int TICK_LONG = 16000;
	// Watchdog period in ms at the reference oscillator rate, as overflows.
	localparam int DOG_PERIOD_MS = 2;
	localparam int OSC_REF_KHZ = 8000;
	localparam int DOG_OSC_PERIODS = DOG_PERIOD_MS * OSC_REF_KHZ;
	localparam int DOG_OVF = DOG_OSC_PERIODS / OVF_OSC_PERIODS;
	// Delay after a wake from halt, in core clocks.
	localparam int WAKE_CLOCKS = 256;
	localparam logic [7:0] WAKE_LAST = 8'(WAKE_CLOCKS - 1);
	// Low power mode codes on the mode input.
	localparam logic [1:0] LP_ACTIVE = 2'h0;
	localparam logic [1:0] LP_WAIT = 2'h1;
	localparam logic [1:0] LP_AHALT = 2'h3;
	// Halt state machine, Gray coded along run, halt, wake.
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_HALT = 2'b01,
		ST_WAKE = 2'b11
	} ltw_state_t;
endpackage
`default_nettype wire

// File: ltw_top.sv
// Lite timer: hidden timebase counter, watchdog, input capture and APB registers.
//
// The APB interface to the registers was chosen for this implementation.
`default_nettype none
module ltw_top #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic lvd_rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_pin,
	input wire logic hw_dog_option,
	input wire logic halt_reset_option,
	input wire logic halt_req,
	input wire logic ext_wake,
	input wire logic [1:0] power_mode,
	input wire logic global_irq_mask,
	output logic tick_irq,
	output logic capture_irq,
	output logic wake_req,
	output logic dog_reset,
	output logic osc_run
);
	// Address decode shared by the read mux and the access side effects.
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ref_a);
		addr_is = (a == ADDR_W'(ref_a));
	endfunction

	logic [4:0] presc_q;
	logic [7:0] cnt_q;
	logic ovf_ph_q;
	logic tick_flag_q;
	logic tick_ie_q;
	logic period_q;
	logic cap_ie_q;
	logic cap_flag_q;
	logic [7:0] cap_q;
	logic dog_en_q;
	logic delay_q;
	logic force_q;
	logic expired_q;
	logic csr_seen_q;
	logic [7:0] wake_cnt_q;
	logic [2:0] pin_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic tick_irq_q;
	logic cap_irq_q;
	logic wake_q;
	logic dog_reset_q;
	ltw_pkg::ltw_state_t st_q;
	logic running;
	logic presc_tick;
	logic ovf;
	logic tick;
	logic period_end;
	logic dog_active;
	logic dog_fire;
	logic done;
	logic wr_csr;
	logic rd_csr;
	logic rd_cap;
	logic cap_edge;
	logic cap_take;
	logic [7:0] csr_val;

	// Access completes on the edge where the slave's ready is seen.
	assign done = psel && penable && pready_q;
	assign wr_csr = done && pwrite && addr_is(paddr, ltw_pkg::CSR_ADDR);
	assign rd_csr = done && !pwrite && addr_is(paddr, ltw_pkg::CSR_ADDR);
	assign rd_cap = done && !pwrite && addr_is(paddr, ltw_pkg::CAP_ADDR);

	// Timer only advances in the run state, so halt freezes it.
	assign running = (st_q == ltw_pkg::ST_RUN);
	assign presc_tick = running && (presc_q == ltw_pkg::PRESC_LAST);
	assign ovf = presc_tick && (cnt_q == ltw_pkg::CNT_TOP);
	assign tick = ovf && (!period_q || ovf_ph_q);
	// Two overflows make one watchdog period.
	assign period_end = ovf && (ovf_ph_q == 1'(ltw_pkg::DOG_OVF - 1));
	assign dog_active = hw_dog_option || dog_en_q;
	assign dog_fire = dog_active && (expired_q || force_q || (halt_req && halt_reset_option));

	assign csr_val = {cap_ie_q, cap_flag_q, period_q, tick_ie_q, tick_flag_q, force_q,
		dog_en_q, delay_q};

	// Capture pin passes two flops before the edge detector looks at it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_q <= 3'h0;
		else
			pin_q <= {pin_q[1:0], capture_pin};
	end
	assign cap_edge = pin_q[2] ^ pin_q[1];
	assign cap_take = cap_edge && (!cap_flag_q || rd_cap);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_q <= 5'h00;
		else if (running)
			presc_q <= presc_q + 5'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= 8'h00;
		else if (ovf)
			cnt_q <= 8'h00;
		else if (presc_tick)
			cnt_q <= cnt_q + 8'h01;
	end

	// Overflow phase serves both the long tick and the watchdog period.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovf_ph_q <= 1'b0;
		else if (ovf)
			ovf_ph_q <= !ovf_ph_q;
	end

	// Software control bits of the control/status register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_ie_q <= 1'b0;
			period_q <= 1'b0;
			tick_ie_q <= 1'b0;
			dog_en_q <= 1'b0;
		end
		else if (wr_csr)
		begin
			cap_ie_q <= pwdata[ltw_pkg::B_CAP_IE];
			period_q <= pwdata[ltw_pkg::B_PERIOD];
			tick_ie_q <= pwdata[ltw_pkg::B_TICK_IE];
			dog_en_q <= pwdata[ltw_pkg::B_DOG_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_flag_q <= 1'b0;
		else if (tick)
			tick_flag_q <= 1'b1;
		else if (rd_csr && prdata_q[ltw_pkg::B_TICK_FLAG]) // A tick unseen by the read survives.
			tick_flag_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_flag_q <= ltw_pkg::CAP_FLAG_RESET;
			cap_q <= ltw_pkg::CAP_RESET;
		end
		else if (cap_take)
		begin
			cap_flag_q <= 1'b1;
			cap_q <= cnt_q;
		end
		else if (rd_cap)
			cap_flag_q <= 1'b0;
	end

	// delay set by software, cleared at period end; a set wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			delay_q <= 1'b0;
		else if (wr_csr && pwdata[ltw_pkg::B_DELAY])
			delay_q <= 1'b1;
		else if (period_end)
			delay_q <= 1'b0;
	end

	// period counted even while disabled; a missed refresh is remembered.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			expired_q <= 1'b0;
		else if (period_end && !delay_q)
			expired_q <= 1'b1;
	end

	// Software may clear the force bit only after reading the status register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			csr_seen_q <= 1'b0;
		else if (rd_csr)
			csr_seen_q <= 1'b1;
		else if (wr_csr)
			csr_seen_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge lvd_rst_n)
	begin
		if (!lvd_rst_n)
			force_q <= 1'b0;
		else if (dog_fire || (wr_csr && pwdata[ltw_pkg::B_FORCE]))
			force_q <= 1'b1;
		else if (wr_csr && csr_seen_q)
			force_q <= 1'b0;
	end

	// device reset held until the system reset answers it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dog_reset_q <= 1'b0;
		else if (dog_fire)
			dog_reset_q <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ltw_pkg::ST_RUN;
		else
		begin
			case (st_q)
				ltw_pkg::ST_RUN:
					if (halt_req && !(halt_reset_option && dog_active))
						st_q <= ltw_pkg::ST_HALT;
				ltw_pkg::ST_HALT:
					if (ext_wake)
						st_q <= ltw_pkg::ST_WAKE;
				ltw_pkg::ST_WAKE:
					if (wake_cnt_q == ltw_pkg::WAKE_LAST)
						st_q <= ltw_pkg::ST_RUN;
				default:
					st_q <= ltw_pkg::ST_RUN;
			endcase
		end
	end

	// Wake delay counter runs only between the wake and the resume.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_cnt_q <= 8'h00;
		else if (st_q == ltw_pkg::ST_WAKE)
			wake_cnt_q <= wake_cnt_q + 8'h01;
		else
			wake_cnt_q <= 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_irq_q <= 1'b0;
			cap_irq_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			tick_irq_q <= tick_flag_q && tick_ie_q && !global_irq_mask;
			cap_irq_q <= cap_flag_q && cap_ie_q && !global_irq_mask;
			wake_q <= (tick_flag_q && tick_ie_q &&
				(power_mode == ltw_pkg::LP_WAIT || power_mode == ltw_pkg::LP_AHALT)) ||
				(cap_flag_q && cap_ie_q && power_mode == ltw_pkg::LP_WAIT);
		end
	end

	// APB slave with one wait state; data sampled before any clear-on-read.
	// old value returned
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= !(addr_is(paddr, ltw_pkg::CSR_ADDR) ||
				addr_is(paddr, ltw_pkg::CAP_ADDR));
			if (pwrite)
				prdata_q <= 32'h0000_0000;
			else if (addr_is(paddr, ltw_pkg::CSR_ADDR))
				prdata_q <= {24'h00_0000, csr_val};
			else if (addr_is(paddr, ltw_pkg::CAP_ADDR))
				prdata_q <= {24'h00_0000, cap_q};
			else
				prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign tick_irq = tick_irq_q;
	assign capture_irq = cap_irq_q;
	assign wake_req = wake_q;
	assign dog_reset = dog_reset_q;
	// The oscillator is reported stopped while halted and through the wake delay.
	assign osc_run = running;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_cnt_step;
		presc_tick && cnt_q != ltw_pkg::CNT_TOP |=> cnt_q == $past(cnt_q) + 8'h01;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

	property p_wrap;
		ovf |=> cnt_q == 8'h00 ##1 cnt_q == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_tick_set;
		tick |=> tick_flag_q;
	endproperty
	a_tick_set: assert property (p_tick_set) else $error("tick flag not set");

	property p_rd_clear;
		rd_csr && prdata_q[ltw_pkg::B_TICK_FLAG] && !tick |=> !tick_flag_q;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("tick flag not cleared");

	property p_force_fire;
		dog_active && force_q |-> ##1 dog_reset_q;
	endproperty
	a_force_fire: assert property (p_force_fire) else $error("no forced reset");

	property p_halt_freeze;
		st_q == ltw_pkg::ST_HALT |=> $stable(cnt_q) && !period_end;
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("timer ran in halt");

	property p_capture;
		cap_edge && !cap_flag_q |=> cap_flag_q && cap_q == $past(cnt_q);
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_cap_hold;
		cap_flag_q && !rd_cap |=> $stable(cap_q) && cap_flag_q;
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capture overwritten");

	property p_tick_irq;
		tick_flag_q && tick_ie_q && !global_irq_mask |=> tick_irq_q;
	endproperty
	a_tick_irq: assert property (p_tick_irq) else $error("tick irq missing");
endmodule
`default_nettype wire

// File: ltw_edge_src.sv
// Behavioural model of the edge source that drives the capture pin.
`default_nettype none
module ltw_edge_src (
	input wire logic pclk,
	output logic capture_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// The pin idles low and moves only when the bench asks for an edge.
	initial capture_pin = 1'h0;
	// Each call flips the pin just after a clock edge, so rising and falling edges alternate.
	task automatic toggle();
		@(posedge pclk);
		capture_pin <= ~capture_pin;
	endtask
endmodule
`default_nettype wire

// File: lite_timebase_watchdog_capture_test.sv
// Self-checking bench for the lite timebase, watchdog and capture block.
`default_nettype none
module lite_timebase_watchdog_capture_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 99000;
	localparam logic [7:0] CSR = ltw_pkg::CSR_ADDR;
	localparam logic [7:0] CAP = ltw_pkg::CAP_ADDR;
	logic pclk, presetn, lvd_rst_n, psel, penable, pwrite, pready, pslverr, capture_pin;
	logic hw_dog_option, halt_reset_option, halt_req, ext_wake, global_irq_mask;
	logic tick_irq, capture_irq, wake_req, dog_reset, osc_run, ti_q;
	logic [1:0] power_mode;
	logic [7:0] paddr, rd;
	logic [31:0] pwdata, prdata;
	int miscompares, n_tests, cyc, n_rise, t_rise, t_prev;

	ltw_top dut (.pclk(pclk), .presetn(presetn), .lvd_rst_n(lvd_rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
		.hw_dog_option(hw_dog_option), .halt_reset_option(halt_reset_option),
		.halt_req(halt_req), .ext_wake(ext_wake), .power_mode(power_mode),
		.global_irq_mask(global_irq_mask), .tick_irq(tick_irq), .capture_irq(capture_irq),
		.wake_req(wake_req), .dog_reset(dog_reset), .osc_run(osc_run));
	ltw_edge_src src (.pclk(pclk), .capture_pin(capture_pin));

	// Free-running clock of 8 ns.
	initial
	begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	// Cycle count, tick interrupt rise times and the hang limit.
	always @(posedge pclk)
	begin
		cyc++;
		ti_q <= tick_irq;
		if (tick_irq === 1'h1 && ti_q !== 1'h1)
		begin
			t_prev = t_rise;
			t_rise = cyc;
			n_rise++;
		end
		if (cyc == LIMIT)
		begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		$display("mismatches %0d of %0d comparisons", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request holds until pready is seen, then an idle cycle follows.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1);
		rd = prdata[7:0];
		chk1("pready_wait", 1'h1, n == 2);
		chk1("pslverr", a != CSR && a != CAP, pslverr);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'h0, a, 8'h00);
	endtask

	task automatic wr(input logic [7:0] d);
		apb(1'h1, CSR, d);
	endtask

	task automatic wrise();
		int k;
		k = n_rise;
		for (int i = 0; i < 17000 && n_rise == k; i++)
			@(posedge pclk);
	endtask

	task automatic dwait(input int lim);
		for (int i = 0; i < lim && dog_reset !== 1'h1; i++)
			@(posedge pclk);
	endtask

	// Device reset, then the force flag is checked and cleared so later enables are safe.
	task automatic rst_clr(input logic fs);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk1("dog_rst_low", 1'h0, dog_reset); // disabled after reset.
		rdr(CSR);
		chk1("force_flag", fs, rd[ltw_pkg::B_FORCE]); // set by watchdog.
		wr(8'h00);
		rdr(CSR);
		chk1("force_clr", 1'h0, rd[ltw_pkg::B_FORCE]); // software clear.
	endtask

	task automatic t_regs();
		rdr(CSR);
		chk8("csr_reset", 8'h00, rd); // reset state.
		rdr(CAP); // first capture read.
		chk8("cap_reset", ltw_pkg::CAP_RESET, rd);
		wr(8'h48);
		rdr(CSR);
		chk8("flag_write", 8'h00, rd); // flags ignore writes.
		apb(1'h1, CAP, 8'hff);
		rdr(CAP);
		chk8("cap_ro", 8'h00, rd);
		apb(1'h1, 8'h34, 8'hff);
		rdr(8'h00);
		chk8("unmapped", 8'h00, rd);
	endtask

	task automatic t_capture();
		logic [7:0] v1;
		int c1, d;
		global_irq_mask <= 1'h1;
		wr(8'h80);
		src.toggle();
		c1 = cyc;
		repeat (100) @(posedge pclk);
		chk1("cap_irq_mask", 1'h0, capture_irq); // global mask.
		src.toggle();
		global_irq_mask <= 1'h0;
		repeat (3) @(posedge pclk);
		chk1("cap_irq", 1'h1, capture_irq); // capture interrupt.
		power_mode <= ltw_pkg::LP_AHALT;
		repeat (3) @(posedge pclk);
		chk1("cap_wake_ahalt", 1'h0, wake_req); // capture does not wake active halt.
		power_mode <= ltw_pkg::LP_WAIT;
		repeat (3) @(posedge pclk);
		chk1("cap_wake_wait", 1'h1, wake_req); // capture wakes wait.
		power_mode <= ltw_pkg::LP_ACTIVE;
		rdr(CSR);
		chk1("cap_flag", 1'h1, rd[ltw_pkg::B_CAP_FLAG]); // flag set.
		rdr(CAP);
		v1 = rd;
		rdr(CSR);
		chk1("cap_flag_clr", 1'h0, rd[ltw_pkg::B_CAP_FLAG]); // cleared by read.
		while (cyc < c1 + 320)
			@(posedge pclk);
		src.toggle();
		repeat (5) @(posedge pclk);
		rdr(CAP);
		d = (int'(rd) - int'(v1) + 250) % 250;
		chk1("cap_delta", 1'h1, d >= 9 && d <= 11); // second edge ignored.
	endtask

	task automatic t_tick();
		wr(8'h10);
		wrise();
		power_mode <= ltw_pkg::LP_AHALT;
		repeat (3) @(posedge pclk);
		chk1("tick_wake", 1'h1, wake_req); // tick wakes active halt.
		power_mode <= ltw_pkg::LP_ACTIVE;
		rdr(CSR);
		chk1("tick_flag", 1'h1, rd[ltw_pkg::B_TICK_FLAG]); // old value read.
		rdr(CSR);
		chk1("tick_clr", 1'h0, rd[ltw_pkg::B_TICK_FLAG]); // cleared by read.
		wrise();
		chk1("gap_short", 1'h1, t_rise - t_prev == ltw_pkg::TICK_SHORT); // short period.
		rdr(CSR);
		wr(8'h30);
		wrise();
		rdr(CSR);
		wrise();
		chk1("gap_long", 1'h1, t_rise - t_prev == ltw_pkg::TICK_LONG); // long period.
		rdr(CSR);
	endtask

	task automatic t_dog();
		wr(8'h02);
		dwait(10);
		chk1("dog_late", 1'h1, dog_reset); // late enable.
		rst_clr(1'h1);
		wr(8'h01); // delay before enable.
		wr(8'h03);
		repeat (20000) @(posedge pclk);
		chk1("dog_held", 1'h0, dog_reset); // delay postpones.
		rdr(CSR);
		chk1("delay_clr", 1'h0, rd[ltw_pkg::B_DELAY]); // hardware clear.
		dwait(15000);
		chk1("dog_fire", 1'h1, dog_reset); // timeout reset.
		rst_clr(1'h1);
		wr(8'h02);
		repeat (20) @(posedge pclk);
		chk1("dog_idle", 1'h0, dog_reset);
		wr(8'h06);
		dwait(10);
		chk1("dog_force", 1'h1, dog_reset); // forced reset.
		rst_clr(1'h1);
	endtask

	task automatic t_halt();
		int n;
		wr(8'h01); // refresh before halt.
		halt_req <= 1'h1;
		@(posedge pclk);
		halt_req <= 1'h0;
		repeat (3) @(posedge pclk);
		chk1("osc_halt", 1'h0, osc_run); // halt stops.
		repeat (20) @(posedge pclk);
		ext_wake <= 1'h1;
		@(posedge pclk);
		ext_wake <= 1'h0;
		n = 0;
		while (osc_run !== 1'h1 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		chk1("wake_gap", 1'h1, n >= 254 && n <= 258); // wake delay.
		hw_dog_option <= 1'h1;
		halt_reset_option <= 1'h1;
		@(posedge pclk);
		halt_req <= 1'h1;
		@(posedge pclk);
		halt_req <= 1'h0;
		dwait(10);
		chk1("halt_rst", 1'h1, dog_reset); // reset on halt.
		hw_dog_option <= 1'h0;
		halt_reset_option <= 1'h0;
		lvd_rst_n <= 1'h0;
		@(posedge pclk);
		lvd_rst_n <= 1'h1;
		rst_clr(1'h0); // detector reset clears force.
	endtask

	// Inputs settle at time zero, reset is held for six cycles, then the scenarios run.
	initial
	begin
		presetn = 1'h0;
		lvd_rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		hw_dog_option = 1'h0;
		halt_reset_option = 1'h0;
		halt_req = 1'h0;
		ext_wake = 1'h0;
		power_mode = ltw_pkg::LP_ACTIVE;
		global_irq_mask = 1'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		lvd_rst_n <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_capture();
		t_tick();
		t_dog();
		t_halt();
		summarize();
	end
endmodule
`default_nettype wire
